// ==== rtl/lsatp_pkg.sv ====
package lsatp_pkg;
  // word and slice shape
  localparam int NB       = 16;   // sample word width
  localparam int NIB      = 4;    // bits per preprocessing slice
  localparam int NA       = 5;    // attributes per bit
  // attribute positions inside a bit's attribute vector
  localparam int A_RISE   = 0;
  localparam int A_FALL   = 1;
  localparam int A_GLI    = 2;
  localparam int A_HIGH   = 3;
  localparam int A_LOW    = 4;
  // trigger levels
  localparam int LVLS     = 8;    // levels in serial arrangement
  localparam int LVL_PAR  = 4;    // levels left when slices run in parallel
  localparam int LW       = 3;    // level index width
  // trace storage
  localparam int ADDR_W   = 10;   // static ram address width
  localparam int DEPTH    = 1024; // samples kept after the trigger
  // timing
  localparam int CLK_MHZ  = 40;   // i_clk rate, parallel trigger rate
  localparam int SER_MHZ  = 20;   // serial trigger rate
  localparam int SER_DIV  = CLK_MHZ / SER_MHZ;
  localparam int CLK_NS   = 25;
  localparam int SRAM_NS  = 35;   // static ram access time
  localparam int SRAM_CYC = (SRAM_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 2;    // read data passes a two-stage synchroniser
  localparam int RD_LAT   = SRAM_CYC + SYNC_CYC;
  localparam int RCW      = 3;    // read wait counter width

  // control states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARM  = 3'b001,
    ST_CAPT = 3'b010,
    ST_UPT  = 3'b011,
    ST_UPG  = 3'b100
  } lsatp_state_t;

  // static ram control lines, shared address
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              ce_b;
    logic              oe_b;
    logic              trace_we_b;
    logic              glitch_we_b;
  } lsatp_sram_t;

  // one word for each of the two rams
  typedef struct packed {
    logic [NB-1:0] trace;
    logic [NB-1:0] glitch;
  } lsatp_word_t;

  // per-level setup write
  typedef struct packed {
    logic                  we;
    logic [LW-1:0]         level;
    logic [NB-1:0][NA-1:0] mask;
    logic [NB-1:0]         pattern;
  } lsatp_cfg_t;

  // a bit matches when every enabled attribute holds, and at least one is enabled
  function automatic logic lsatp_bit_match(input logic [NA-1:0] attr, input logic [NA-1:0] msk);
    return (msk != '0) && ((attr & msk) == msk);
  endfunction : lsatp_bit_match
endpackage : lsatp_pkg

// ==== rtl/lsatp_top.sv ====
`timescale 1ns/100ps
module lsatp_top
  import lsatp_pkg::*;
#(
  parameter int DEPTH_P = DEPTH
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  // probe samples and run control
  input  wire logic [NB-1:0] i_sample,
  input  wire logic          i_serial,
  input  wire logic          i_arm,
  input  wire lsatp_cfg_t    i_cfg,
  // static ram
  output lsatp_sram_t        o_sram,
  output lsatp_word_t        o_sram_wdata,
  input  wire lsatp_word_t   i_sram_rdata,
  // host upload
  output logic [NB-1:0]      o_up_data,
  output logic               o_up_valid,
  output logic               o_up_glitch,
  input  wire logic          i_up_ready,
  // status
  output logic [LW-1:0]      o_level,
  output logic               o_hit,
  output logic               o_busy,
  output logic               o_done
);

  logic [NB-1:0]         smp_s1, smp_s2, smp_s3;  // pin synchroniser plus one history stage
  logic [NB-1:0]         smp_last;                // value at previous sample point
  lsatp_word_t           rd_s1, rd_s2;            // ram read data synchroniser
  logic [NB-1:0]         chg;                     // transition seen this clock
  logic [NB-1:0][1:0]    tcnt;                    // transitions since last sample point
  logic [NB-1:0]         glitch_now, hit_now;
  logic [NB-1:0][NA-1:0] attr;
  logic [1:0]            div_cnt;                 // serial rate divider
  logic                  sen, sen_q;              // sample enable, and its stage-two copy
  logic [NB-1:0]         hits_q, glitch_q, samp_q;
  logic                  hit_any;
  logic [NB-1:0][NA-1:0] mask_mem [LVLS];         // attribute mask per level
  logic [NB-1:0]         pat_mem [LVLS];          // selection pattern per level
  lsatp_state_t          st;
  logic [LW-1:0]         last_lvl;
  logic [ADDR_W-1:0]     ptr;                     // write and read pointer
  logic [ADDR_W-1:0]     ptr_end;
  logic [RCW-1:0]        rd_cnt;                  // wait for ram read data
  logic                  up_phase;

  assign chg      = smp_s2 ^ smp_s3;
  assign hit_any  = sen_q && (hits_q != '0);
  assign ptr_end  = ADDR_W'(DEPTH_P - 1);
  assign up_phase = (st == ST_UPT) || (st == ST_UPG);
  // fewer levels fit when the slices share the work in parallel
  assign last_lvl = i_serial ? LW'(LVLS - 1) : LW'(LVL_PAR - 1);

  // two-stage synchronisers for pins and ram read bus
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      smp_s1 <= '0;
      smp_s2 <= '0;
      smp_s3 <= '0;
      rd_s1  <= '0;
      rd_s2  <= '0;
    end else begin
      smp_s1 <= i_sample;
      smp_s2 <= smp_s1;
      smp_s3 <= smp_s2;
      rd_s1  <= i_sram_rdata;
      rd_s2  <= rd_s1;
    end
  end

  // sample enable: every clock in parallel, every other clock in serial
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_cnt <= '0;
      sen     <= 1'b0;
    end else if (!i_serial) begin
      div_cnt <= '0;
      sen     <= 1'b1;
    end else if (div_cnt == 2'(SER_DIV - 1)) begin
      div_cnt <= '0;
      sen     <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 2'h1;
      sen     <= 1'b0;
    end
  end

  // transition counter, restarted at each sample point
  // parallel mode sees one clock per sample, so it cannot flag glitches
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tcnt <= '0;
    end else begin
      for (int b = 0; b < NB; b++) begin
        if (sen) begin
          tcnt[b] <= 2'h0;
        end else if (chg[b] && tcnt[b] != 2'h2) begin
          tcnt[b] <= tcnt[b] + 2'h1;
        end
      end
    end
  end

  // setup memories, written any time
  always_ff @(posedge i_clk) begin
    if (i_cfg.we) begin
      mask_mem[i_cfg.level] <= i_cfg.mask;
      pat_mem[i_cfg.level]  <= i_cfg.pattern;
    end
  end

  // preprocessing slices, one nibble each
  for (genvar n = 0; n < NB / NIB; n++) begin : g_nib
    for (genvar k = 0; k < NIB; k++) begin : g_bit
      localparam int B = n * NIB + k;
      // every attribute is always evaluated
      assign attr[B][A_RISE] = ~smp_last[B] & smp_s2[B];
      assign attr[B][A_FALL] = smp_last[B] & ~smp_s2[B];
      assign attr[B][A_GLI]  = glitch_now[B];
      assign attr[B][A_HIGH] = smp_s2[B];
      assign attr[B][A_LOW]  = ~smp_s2[B];
      // more than one change between sample points
      assign glitch_now[B]   = (tcnt[B] + {1'b0, chg[B]}) >= 2'h2;
      // mask selects attributes, pattern selects bits
      assign hit_now[B] = lsatp_bit_match(attr[B], mask_mem[o_level][B]) & pat_mem[o_level][B];
    end
  end

  // stage register at each sample point
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      smp_last <= '0;
      hits_q   <= '0;
      glitch_q <= '0;
      samp_q   <= '0;
      sen_q    <= 1'b0;
      o_hit    <= 1'b0;
    end else begin
      sen_q <= sen;
      o_hit <= hit_any;
      if (sen) begin
        smp_last <= smp_s2;
        // hits only count while armed; a sample judged while the level steps
        // saw the old level's setup, so it is dropped (costs one sample)
        hits_q   <= (st == ST_ARM && !hit_any) ? hit_now : '0;
        glitch_q <= glitch_now;
        samp_q   <= smp_s2;
      end
    end
  end

  // trigger, capture and upload sequencing
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st      <= ST_IDLE;
      o_level <= '0;
      ptr     <= '0;
      o_done  <= 1'b0;
      o_busy  <= 1'b0;
    end else begin
      o_busy <= (st != ST_IDLE);
      case (st)
        ST_IDLE: begin
          if (i_arm) begin
            st      <= ST_ARM;
            o_level <= '0;
            o_done  <= 1'b0;
          end
        end
        ST_ARM: begin
          // each level waits for any selected hit
          if (hit_any) begin
            if (o_level == last_lvl) begin
              st  <= ST_CAPT;
              ptr <= '0;
            end else begin
              o_level <= o_level + LW'(1);
            end
          end
        end
        ST_CAPT: begin
          if (sen_q) begin
            if (ptr == ptr_end) begin
              st  <= ST_UPT;
              ptr <= '0;
            end else begin
              ptr <= ptr + ADDR_W'(1);
            end
          end
        end
        ST_UPT, ST_UPG: begin
          if (o_up_valid && i_up_ready) begin
            if (ptr != ptr_end) begin
              ptr <= ptr + ADDR_W'(1);
            end else if (st == ST_UPT) begin
              st  <= ST_UPG;
              ptr <= '0;
            end else begin
              st     <= ST_IDLE;
              o_done <= 1'b1;
            end
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // static ram control and write data
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sram       <= '{addr: '0, ce_b: 1'b1, oe_b: 1'b1, trace_we_b: 1'b1, glitch_we_b: 1'b1};
      o_sram_wdata <= '0;
    end else begin
      o_sram.ce_b        <= !((st == ST_CAPT) || up_phase);
      o_sram.oe_b        <= !up_phase;
      o_sram.trace_we_b  <= 1'b1;
      o_sram.glitch_we_b <= 1'b1;
      if (up_phase) begin
        o_sram.addr <= ptr;
      end else if (st == ST_CAPT && sen_q) begin
        // both rams written in one cycle at one address
        o_sram.addr         <= ptr;
        o_sram.trace_we_b   <= 1'b0;
        o_sram.glitch_we_b  <= 1'b0;
        o_sram_wdata.trace  <= samp_q;
        for (int i = 0; i < NB / 8; i++) begin
          o_sram_wdata.glitch[i*8 +: 8] <= {glitch_q[i*8+NIB +: NIB], glitch_q[i*8 +: NIB]};
        end
      end
    end
  end

  // upload: wait for read data, hand one word to the host at a time
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_cnt      <= '0;
      o_up_valid  <= 1'b0;
      o_up_data   <= '0;
      o_up_glitch <= 1'b0;
    end else if (!up_phase) begin
      rd_cnt     <= '0;
      o_up_valid <= 1'b0;
    end else if (o_up_valid && i_up_ready) begin
      rd_cnt     <= '0;
      o_up_valid <= 1'b0;
    end else if (rd_cnt != RCW'(RD_LAT)) begin
      rd_cnt <= rd_cnt + RCW'(1);
    end else if (!o_up_valid) begin
      o_up_valid  <= 1'b1;
      o_up_data   <= (st == ST_UPG) ? rd_s2.glitch : rd_s2.trace;
      o_up_glitch <= (st == ST_UPG);
    end
  end

  // checks
  sequence s_handshake;
    o_up_valid && i_up_ready && ptr != ptr_end;
  endsequence
  sequence s_read_wait;
    !o_up_valid [*5] ##1 o_up_valid;
  endsequence

  a_hit_pattern: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sen |=> (hits_q & ~$past(pat_mem[o_level])) == '0)
    else $error("hit on a bit the pattern did not select");
  a_mask_empty: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sen && mask_mem[o_level] == '0 |=> hits_q == '0)
    else $error("hit with no attribute enabled");
  a_par_noglitch: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_serial && $past(!i_serial) && sen |=> glitch_q == '0)
    else $error("glitch flagged with one clock per sample");
  a_level_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == ST_ARM && !hit_any |=> $stable(o_level))
    else $error("level moved without a hit");
  a_trig_enter: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == ST_ARM && hit_any && o_level == last_lvl |=> st == ST_CAPT && ptr == '0)
    else $error("last level hit did not start capture");
  a_dual_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == ST_CAPT && sen_q |=> !o_sram.trace_we_b && !o_sram.glitch_we_b
      && o_sram_wdata.trace == $past(samp_q))
    else $error("trace and glitch not written together");
  a_up_order: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == ST_UPG && $past(st) != ST_UPG |-> $past(st) == ST_UPT && ptr == '0)
    else $error("glitch upload not preceded by trace upload");
  a_serial_rate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_serial && $past(i_serial) && sen |=> !sen ##1 sen)
    else $error("serial sample rate is not half the clock");
  a_par_rate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_serial ##1 !i_serial |-> sen)
    else $error("parallel sample enable missing");
  a_read_latency: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_handshake ##0 up_phase |=> s_read_wait)
    else $error("upload word not presented after read wait");
  a_step_once: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == ST_ARM && hit_any |=> !hit_any)
    else $error("one hit stepped more than one level");

endmodule : lsatp_top

// ==== verif/lsatp_sram_model.sv ====
`timescale 1ns/100ps
// trace and glitch static ram pair on one shared address bus
module lsatp_sram_model
  import lsatp_pkg::*;
(
  // ram control from the block
  input  wire logic        i_clk,
  input  wire lsatp_sram_t i_sram,
  input  wire lsatp_word_t i_wdata,
  // read data back to the block
  output lsatp_word_t      o_rdata
);
  lsatp_word_t mem [1024]; // both rams, one entry per address
  lsatp_word_t last = '0;  // last word driven onto the bus
  logic        rd_en;      // chip and output enabled
  assign rd_en = !i_sram.ce_b && !i_sram.oe_b;
  // released bus shows the inverse, so a stale word cannot pass
  assign o_rdata = rd_en ? mem[i_sram.addr] : ~last;
  // each ram writes on its own strobe, at the edge
  always @(posedge i_clk) begin
    if (!i_sram.ce_b && !i_sram.trace_we_b) mem[i_sram.addr].trace <= i_wdata.trace;
    if (!i_sram.ce_b && !i_sram.glitch_we_b) mem[i_sram.addr].glitch <= i_wdata.glitch;
    if (rd_en) last <= mem[i_sram.addr];
  end
endmodule : lsatp_sram_model

// ==== verif/lsatp_top_tb.sv ====
`timescale 1ns/100ps
// bench for the trigger and capture path, bench acts as host
module lsatp_top_tb
  import lsatp_pkg::*;
;
  localparam int DP = 8;         // short capture depth
  logic          clk = 1'b0;     // 40 MHz clock
  logic          rst_b = 1'b0;   // async reset
  logic [NB-1:0] sample = '0;    // probe word
  logic          tog = 1'b0;     // bit 0 toggler
  logic          tog_en = 1'b0;  // toggler on
  logic          serial = 1'b0;  // arrangement select
  logic          arm = 1'b0;     // run start
  logic          ready = 1'b0;   // host ready
  lsatp_cfg_t    cfg = '0;       // level setup
  lsatp_sram_t   sram;           // ram control
  lsatp_word_t   wdata;          // ram write data
  lsatp_word_t   rdata;          // ram read data
  logic [NB-1:0] up_data;        // upload word
  logic          up_valid;       // upload valid
  logic          up_glitch;      // glitch word flag
  logic          hit;            // hit pulse
  logic          busy;           // run active
  logic          done;           // upload finished
  logic [LW-1:0] level;          // trigger level
  int            fail_count = 0; // mismatches
  int            check_count = 0;// comparisons
  int            wcnt = 0;       // ram writes seen

  always #12.5 clk = ~clk;
  // two toggles per serial sample point make a glitch
  always @(posedge clk) if (tog_en) #1 tog = ~tog;

  lsatp_top #(.DEPTH_P(DP)) lsatp_top_i (
    .i_clk(clk), .i_rst_b(rst_b), .i_sample(sample ^ {15'h0, tog}), .i_serial(serial),
    .i_arm(arm), .i_cfg(cfg), .o_sram(sram), .o_sram_wdata(wdata), .i_sram_rdata(rdata),
    .o_up_data(up_data), .o_up_valid(up_valid), .o_up_glitch(up_glitch), .i_up_ready(ready),
    .o_level(level), .o_hit(hit), .o_busy(busy), .o_done(done));
  lsatp_sram_model lsatp_sram_model_i (.i_clk(clk), .i_sram(sram), .i_wdata(wdata), .o_rdata(rdata));

  task automatic check(input logic [NB-1:0] seen, input logic [NB-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // all drives land 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // writes must pair both rams at the next address
  always @(posedge clk) begin
    if (sram.trace_we_b === 1'b0) begin
      check(16'(sram.addr), 16'(wcnt));
      check(16'({sram.glitch_we_b, sram.ce_b}), 16'h0);
      wcnt++;
    end
  end

  // one level entry: attribute a on bit b, decoy d masked but not selected
  task automatic set_lvl(input int lv, input int b, input int a, input int d);
    lsatp_cfg_t c;
    c = '0;
    c.we = 1'b1;
    c.level = LW'(lv);
    c.mask[b][a] = 1'b1;
    if (d >= 0) c.mask[d][A_HIGH] = 1'b1;
    c.pattern = 16'h1 << b;
    cfg = c;
    tick(1);
    cfg.we = 1'b0;
    tick(1);
  endtask : set_lvl

  task automatic wait_lvl(input logic [LW-1:0] v);
    int n;
    n = 0;
    while (level !== v && n < 20) begin
      tick(1);
      n++;
    end
    check(16'(level), 16'(v));
    check(16'(hit), 16'h1);
  endtask : wait_lvl

  task automatic start_run();
    int n;
    wcnt = 0;
    arm = 1'b1;
    tick(1);
    arm = 1'b0;
    tick(4);
    check(16'({busy, done}), 16'h2);
  endtask : start_run

  task automatic wait_capt();
    int n;
    n = 0;
    while (wcnt < DP && n < 100) begin
      tick(1);
      n++;
    end
    check(16'(wcnt), 16'(DP));
  endtask : wait_capt

  // host side: stall, judge held word, then take it
  task automatic upload(input logic [NB-1:0] tr, input logic [NB-1:0] tm, input logic [NB-1:0] gl);
    int n;
    for (int w = 0; w < 2 * DP; w++) begin
      n = 0;
      while (up_valid !== 1'b1 && n < 30) begin
        tick(1);
        n++;
      end
      tick(2);
      check(16'({up_valid, up_glitch}), 16'({1'b1, w >= DP}));
      check((w < DP) ? (up_data & tm) : up_data, (w < DP) ? tr : gl);
      ready = 1'b1;
      tick(1);
      ready = 1'b0;
    end
    tick(3);
    check(16'({busy, done}), 16'h1);
  endtask : upload

  task automatic reset_test();
    tick(10);
    check(16'({sram.ce_b, sram.oe_b, sram.trace_we_b, sram.glitch_we_b}), 16'hf);
    check(16'({up_valid, busy, done, hit, level}), 16'h0);
    rst_b = 1'b1;
    tick(3);
    $display("test reset done");
  endtask : reset_test

  // four bits, four different attributes, one per level
  task automatic par_test();
    sample = 16'h000a;
    set_lvl(0, 0, A_RISE, 4);
    set_lvl(1, 1, A_FALL, -1);
    set_lvl(2, 2, A_HIGH, -1);
    set_lvl(3, 3, A_LOW, -1);
    start_run();
    sample[4] = 1'b1;
    tick(6);
    check(16'(level), 16'h0);
    sample[0] = 1'b1;
    wait_lvl(1);
    sample[1] = 1'b0;
    wait_lvl(2);
    tick(4);
    check(16'(level), 16'h2);
    sample[2] = 1'b1;
    wait_lvl(3);
    sample[3] = 1'b0;
    wait_capt();
    upload(16'h0015, 16'hffff, 16'h0000);
    $display("test parallel done");
  endtask : par_test

  // eight levels then capture, bit 0 glitching throughout
  task automatic ser_test();
    serial = 1'b1;
    tog_en = 1'b1;
    sample = '0;
    for (int l = 0; l < LVLS; l++) set_lvl(l, l + 1, A_HIGH, -1);
    start_run();
    for (int l = 0; l < LVLS; l++) begin
      sample[l+1] = 1'b1;
      if (l < LVLS - 1) wait_lvl(LW'(l + 1));
    end
    wait_capt();
    upload(16'h01fe, 16'hfffe, 16'h0001);
    $display("test serial done");
  endtask : ser_test

  initial begin
    reset_test();
    par_test();
    ser_test();
    conclude();
  end

  // watchdog, runs take well under 1500 cycles
  initial begin
    #(CLK_NS * 4000);
    fail_count++;
    conclude();
  end
endmodule : lsatp_top_tb
